// ==== design/cplft_pkg.sv ====
// Contract
// - sysclk divide 1, 2, 4 or 12
// - converter clock is undivided fast oscillator
// - 8-bit trim nudges fast oscillator frequency
// - trim loads per-chip factory value at power-on
// - wake-up timer runs only while run bit set
// - period sets flag, cleared on interrupt accept
// - period select 15.625 ms doubling, 1xxx 4 s
// - timer source slow RC or crystal
// - wake-up timer keeps running in STOP
// - power bit 1 stops oscillator, enters STOP
// - STOP left on ext irq, timer, watchdog
// - power bit 0 enters IDLE, clocks run
// - IDLE left on any enabled interrupt
// - power register write-only, bits reset zero
package cplft_pkg;
	// ==========================================
	// register indices, byte address is four times index
	localparam logic [7:0] REG_TRIM_IDX  = 8'h83;
	localparam logic [7:0] REG_POWER_MODE_CONTROL_IDX  = 8'h87;
	localparam logic [7:0] REG_OPT_IDX   = 8'hC1;
	localparam logic [7:0] REG_BTM_IDX   = 8'hCE;
	localparam logic [7:0] REG_ISTAT_IDX = 8'hE0;
	localparam logic [7:0] REG_IMASK_IDX = 8'hE1;
	localparam logic [7:0] REG_MODE_IDX  = 8'hE2;
	// ==========================================
	// field positions
	localparam int BTM_RUN_BIT   = 7;
	localparam int BTM_FLAG_BIT  = 6;
	localparam int POWER_MODE_CONTROL_BAUD_BIT = 7;
	localparam int POWER_MODE_CONTROL_STOP_BIT = 1;
	localparam int POWER_MODE_CONTROL_IDLE_BIT = 0;
	localparam int OPT_XTAL_BIT  = 6;
	localparam int OPT_DIV_LO    = 4;
	localparam int IRQ_TMR_BIT   = 0;
	localparam int IRQ_STOPW_BIT = 1;
	localparam int IRQ_IDLEW_BIT = 2;
	// ==========================================
	// reset values
	localparam logic [3:0] BTM_SEL_RESET = 4'h0;
	localparam logic [2:0] IRQ_RESET     = 3'h0;
	// ==========================================
	// divider codes and their terminal counts
	localparam logic [1:0] DIV1_CODE  = 2'h0;
	localparam logic [1:0] DIV2_CODE  = 2'h1;
	localparam logic [1:0] DIV4_CODE  = 2'h2;
	localparam logic [3:0] DIV12_LAST = 4'hB;
	localparam logic [3:0] DIV4_LAST  = 4'h3;
	localparam logic [3:0] DIV2_LAST  = 4'h1;
	// ==========================================
	// timer timing: base tick 32768 Hz, shortest period 15625 us
	localparam int LF_BASE_HZ     = 32768;
	localparam int BASE_PERIOD_US = 15625;
	localparam int BASE_PERIOD_CNT = BASE_PERIOD_US * LF_BASE_HZ / 1000000;
	localparam logic [1:0] LRC_PRESCALE_LAST = 2'h3;
	// ==========================================
	// operating modes
	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_IDLE,
		MODE_STOP
	} cplft_mode_type;
endpackage

// ==== design/cplft_top.sv ====
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// clock divider, power modes and low-frequency wake-up timer
module cplft_top (
	// clock and reset
	input  wire logic        MCLK,
	input  wire logic        RESETN,
	// apb slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// power-on load values
	input  wire logic [7:0]  FACTORY_TRIM,
	input  wire logic [7:0]  FACTORY_OPTION,
	// low-frequency clock pins
	input  wire logic        SLOW_RC_OSC,
	input  wire logic        XTAL_CLK,
	// wake and interrupt sources
	input  wire logic [2:0]  EXT_IRQ_INPUTS,
	input  wire logic        WDT_EVENT,
	input  wire logic        IRQ_PENDING,
	input  wire logic        WTIMER_IRQ_ACK,
	// clock outputs
	output logic             SYSCLK_TICK,
	output logic             CONV_CLK_EN,
	output logic             FAST_RC_OSC_EN,
	output logic [7:0]       FAST_OSC_TRIM,
	// status outputs
	output logic             CPU_HALT,
	output logic             CRYSTAL_SELECT,
	output logic             BAUD_DOUBLE,
	output logic             WAKEUP_TIMER_FLAG,
	output logic             IRQ
);
	// ==========================================
	// all state of the block apart from the wake-up timer counter
	typedef struct packed {
		logic [7:0]                trim;
		logic [7:0]                opt;
		logic                      baud;
		logic                      btm_run;
		logic                      btm_flag;
		logic [3:0]                btm_sel;
		cplft_pkg::cplft_mode_type mode;
		logic [2:0]                stat;
		logic [2:0]                mask;
		logic                      loaded;
		logic [2:0]                ext_s1;
		logic [2:0]                ext_s2;
		logic                      lf_s1;
		logic                      lf_s2;
		logic                      lf_prev;
		logic [1:0]                lf_pre;
		logic                      lf_tick;
		logic [3:0]                div_cnt;
		logic                      sys_tick;
		logic                      pready;
		logic [31:0]               prdata;
		logic                      pslverr;
		logic                      irq;
		logic                      osc_en;  // oscillator and converter clock enable
		logic                      halt;    // cpu held in idle or stop
	} cplft_state_type;

	cplft_state_type st_ff;
	cplft_state_type nxt_st;
	logic            period_pulse; // selected timer period elapsed
	logic [7:0]      idx;          // register index of the access
	logic            wr_en;        // write completes this edge
	logic            lf_src;       // selected low-frequency pin
	logic            stop_wake;    // stop exit condition
	logic            idle_wake;    // idle exit condition
	logic [3:0]      div_last;     // divider terminal count
	logic [2:0]      stat_set;     // events this cycle

	// ==========================================
	// register index check
	function automatic logic idx_mapped(input logic [7:0] i);
		case (i)
			cplft_pkg::REG_TRIM_IDX,
			cplft_pkg::REG_POWER_MODE_CONTROL_IDX,
			cplft_pkg::REG_OPT_IDX,
			cplft_pkg::REG_BTM_IDX,
			cplft_pkg::REG_ISTAT_IDX,
			cplft_pkg::REG_IMASK_IDX,
			cplft_pkg::REG_MODE_IDX: idx_mapped = 1'b1;
			default:                 idx_mapped = 1'b0;
		endcase
	endfunction

	// ==========================================
	// wake-up timer counter
	cplft_wtimer u_wtimer (
		.clk          (MCLK),
		.rst_n        (RESETN),
		.lf_tick      (st_ff.lf_tick),
		.run          (st_ff.btm_run),
		.sel          (st_ff.btm_sel),
		.period_pulse (period_pulse)
	);

	// ==========================================
	// decode helpers
	always_comb begin
		idx = PADDR[9:2];
		wr_en = PSEL && PENABLE && PWRITE && st_ff.pready;
		// crystal or slow rc feeds the timer
		lf_src = st_ff.opt[cplft_pkg::OPT_XTAL_BIT] ? XTAL_CLK : SLOW_RC_OSC;
		// stop exits on external irq, timer period or watchdog
		stop_wake = (|st_ff.ext_s2) || period_pulse || WDT_EVENT;
		// idle exits on any enabled interrupt
		idle_wake = IRQ_PENDING || stop_wake;
		// divider terminal count by selection
		case (st_ff.opt[cplft_pkg::OPT_DIV_LO +: 2])
			cplft_pkg::DIV1_CODE: div_last = 4'h0;
			cplft_pkg::DIV2_CODE: div_last = cplft_pkg::DIV2_LAST;
			cplft_pkg::DIV4_CODE: div_last = cplft_pkg::DIV4_LAST;
			default:              div_last = cplft_pkg::DIV12_LAST;
		endcase
	end

	// ==========================================
	// next-state logic
	always_comb begin
		nxt_st = st_ff;
		stat_set = 3'h0;

		// power-on load of factory trim and option, once after release
		if (!st_ff.loaded) begin
			nxt_st.loaded = 1'b1;
			nxt_st.trim = FACTORY_TRIM;
			nxt_st.opt = FACTORY_OPTION;
		end

		// pin synchronisers
		nxt_st.ext_s1 = EXT_IRQ_INPUTS;
		nxt_st.ext_s2 = st_ff.ext_s1;
		nxt_st.lf_s1 = lf_src;
		nxt_st.lf_s2 = st_ff.lf_s1;
		nxt_st.lf_prev = st_ff.lf_s2;

		// base tick: crystal edges direct, slow rc divided by four
		nxt_st.lf_tick = 1'b0;
		if (st_ff.lf_s2 && !st_ff.lf_prev) begin
			if (st_ff.opt[cplft_pkg::OPT_XTAL_BIT]) begin
				nxt_st.lf_tick = 1'b1;
			end else begin
				nxt_st.lf_pre = st_ff.lf_pre + 2'h1;
				nxt_st.lf_tick = (st_ff.lf_pre == cplft_pkg::LRC_PRESCALE_LAST);
			end
		end

		// mode machine, wake clears the mode bits
		case (st_ff.mode)
			cplft_pkg::MODE_RUN: begin
			end
			cplft_pkg::MODE_IDLE: begin
				if (idle_wake) begin
					nxt_st.mode = cplft_pkg::MODE_RUN;
					stat_set[cplft_pkg::IRQ_IDLEW_BIT] = 1'b1;
				end
			end
			cplft_pkg::MODE_STOP: begin
				if (stop_wake) begin
					nxt_st.mode = cplft_pkg::MODE_RUN;
					stat_set[cplft_pkg::IRQ_STOPW_BIT] = 1'b1;
				end
			end
			default: nxt_st.mode = cplft_pkg::MODE_RUN;
		endcase

		// apb answer: prepared in setup, ready in access
		nxt_st.pready = 1'b0;
		if (PSEL && !PENABLE) begin
			nxt_st.pready = 1'b1;
			nxt_st.pslverr = !idx_mapped(idx);
			nxt_st.prdata = 32'h0;
			if (!PWRITE) begin
				case (idx)
					cplft_pkg::REG_TRIM_IDX:  nxt_st.prdata[7:0] = st_ff.trim;
					cplft_pkg::REG_OPT_IDX:   nxt_st.prdata[7:0] = st_ff.opt;
					cplft_pkg::REG_BTM_IDX: begin
						nxt_st.prdata[cplft_pkg::BTM_RUN_BIT] = st_ff.btm_run;
						nxt_st.prdata[cplft_pkg::BTM_FLAG_BIT] = st_ff.btm_flag;
						nxt_st.prdata[3:0] = st_ff.btm_sel;
					end
					cplft_pkg::REG_ISTAT_IDX: nxt_st.prdata[2:0] = st_ff.stat;
					cplft_pkg::REG_IMASK_IDX: nxt_st.prdata[2:0] = st_ff.mask;
					cplft_pkg::REG_MODE_IDX:  nxt_st.prdata[1:0] = st_ff.mode;
					// power register is write-only and reads zero
					default:                  nxt_st.prdata = 32'h0;
				endcase
			end
		end

		// register writes at the completing edge
		if (wr_en) begin
			case (idx)
				cplft_pkg::REG_TRIM_IDX: nxt_st.trim = PWDATA[7:0];
				cplft_pkg::REG_OPT_IDX:  nxt_st.opt = PWDATA[7:0];
				cplft_pkg::REG_BTM_IDX: begin
					nxt_st.btm_run = PWDATA[cplft_pkg::BTM_RUN_BIT];
					nxt_st.btm_flag = PWDATA[cplft_pkg::BTM_FLAG_BIT];
					nxt_st.btm_sel = PWDATA[3:0];
				end
				cplft_pkg::REG_POWER_MODE_CONTROL_IDX: begin
					nxt_st.baud = PWDATA[cplft_pkg::POWER_MODE_CONTROL_BAUD_BIT];
					// stop takes priority when both bits are written
					if (PWDATA[cplft_pkg::POWER_MODE_CONTROL_STOP_BIT]) begin
						nxt_st.mode = cplft_pkg::MODE_STOP;
					end else if (PWDATA[cplft_pkg::POWER_MODE_CONTROL_IDLE_BIT]) begin
						nxt_st.mode = cplft_pkg::MODE_IDLE;
					end
				end
				cplft_pkg::REG_ISTAT_IDX: nxt_st.stat = st_ff.stat & ~PWDATA[2:0];
				cplft_pkg::REG_IMASK_IDX: nxt_st.mask = PWDATA[2:0];
				default: begin
				end
			endcase
		end

		// timer flag: accept clears it, a new period wins
		if (WTIMER_IRQ_ACK) begin
			nxt_st.btm_flag = 1'b0;
		end
		if (period_pulse) begin
			nxt_st.btm_flag = 1'b1;
			stat_set[cplft_pkg::IRQ_TMR_BIT] = 1'b1;
		end

		// system clock strobe from the divider, none from the edge that enters stop
		nxt_st.sys_tick = 1'b0;
		if (nxt_st.mode == cplft_pkg::MODE_STOP) begin
			nxt_st.div_cnt = 4'h0;
		end else if (st_ff.div_cnt >= div_last) begin
			nxt_st.div_cnt = 4'h0;
			nxt_st.sys_tick = 1'b1;
		end else begin
			nxt_st.div_cnt = st_ff.div_cnt + 4'h1;
		end

		// registered mode decodes so the outputs come from flops
		nxt_st.osc_en = (nxt_st.mode != cplft_pkg::MODE_STOP);
		nxt_st.halt = (nxt_st.mode != cplft_pkg::MODE_RUN);

		// sticky status, set wins over a write-one clear
		nxt_st.stat = nxt_st.stat | stat_set;
		nxt_st.irq = |(nxt_st.stat & nxt_st.mask);
	end

	// ==========================================
	// state register
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			st_ff <= '0;
			st_ff.btm_sel <= cplft_pkg::BTM_SEL_RESET;
			st_ff.mode <= cplft_pkg::MODE_RUN;
			st_ff.stat <= cplft_pkg::IRQ_RESET;
			st_ff.mask <= cplft_pkg::IRQ_RESET;
			st_ff.osc_en <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ==========================================
	// outputs, each a field of the state register
	assign PRDATA = st_ff.prdata;
	assign PREADY = st_ff.pready;
	assign PSLVERR = st_ff.pslverr;
	assign SYSCLK_TICK = st_ff.sys_tick;
	// converter clock follows the oscillator, not the divider
	assign CONV_CLK_EN = st_ff.osc_en;
	// oscillator stopped only in stop, restarted on wake, timer untouched
	assign FAST_RC_OSC_EN = st_ff.osc_en;
	assign FAST_OSC_TRIM = st_ff.trim;
	assign CPU_HALT = st_ff.halt;
	assign CRYSTAL_SELECT = st_ff.opt[cplft_pkg::OPT_XTAL_BIT];
	assign BAUD_DOUBLE = st_ff.baud;
	assign WAKEUP_TIMER_FLAG = st_ff.btm_flag;
	assign IRQ = st_ff.irq;
endmodule // cplft_top
`default_nettype wire

// ==== design/cplft_wtimer.sv ====
`timescale 1ns/1ps
`default_nettype none
// wake-up timer: counts base ticks and pulses at the selected period
module cplft_wtimer (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// control
	input  wire logic       lf_tick,
	input  wire logic       run,
	input  wire logic [3:0] sel,
	// event
	output logic            period_pulse
);
	// ==========================================
	// state
	typedef struct packed {
		logic [16:0] cnt;
		logic        pulse;
	} cplft_wt_state_type;

	cplft_wt_state_type st_ff;
	cplft_wt_state_type nxt_st;
	logic [16:0]        last_cnt; // terminal count for this selection

	// ==========================================
	// period select: doubling per code, any 1xxx is the longest
	always_comb begin
		if (sel[3]) begin
			last_cnt = 17'(cplft_pkg::BASE_PERIOD_CNT << 8) - 17'h1;
		end else begin
			last_cnt = 17'(cplft_pkg::BASE_PERIOD_CNT << sel[2:0]) - 17'h1;
		end
	end

	// ==========================================
	// counter, held at zero while stopped
	always_comb begin
		nxt_st = st_ff;
		nxt_st.pulse = 1'b0;
		if (!run) begin
			nxt_st.cnt = 17'h0;
		end else if (lf_tick) begin
			if (st_ff.cnt >= last_cnt) begin
				nxt_st.cnt = 17'h0;
				nxt_st.pulse = 1'b1;
			end else begin
				nxt_st.cnt = st_ff.cnt + 17'h1;
			end
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign period_pulse = st_ff.pulse;
endmodule // cplft_wtimer
`default_nettype wire

// ==== testbench/cplft_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====
// port checker for the power and wake-up block
module cplft_chk (
	// clock and reset
	input	wire logic		MCLK,
	input	wire logic		RESETN,
	// register bus
	input	wire logic		PSEL,
	input	wire logic		PENABLE,
	input	wire logic		PWRITE,
	input	wire logic [11:0]	PADDR,
	input	wire logic [31:0]	PWDATA,
	input	wire logic [31:0]	PRDATA,
	input	wire logic		PREADY,
	// wake sources
	input	wire logic [2:0]	EXT_IRQ_INPUTS,
	input	wire logic		WDT_EVENT,
	input	wire logic		IRQ_PENDING,
	input	wire logic		WTIMER_IRQ_ACK,
	// outputs watched
	input	wire logic		SYSCLK_TICK,
	input	wire logic		CONV_CLK_EN,
	input	wire logic		FAST_RC_OSC_EN,
	input	wire logic [7:0]	FAST_OSC_TRIM,
	input	wire logic		CPU_HALT,
	input	wire logic		CRYSTAL_SELECT,
	input	wire logic		WAKEUP_TIMER_FLAG
);
	// completed access and its register index
	wire		acc	= PSEL && PENABLE && PREADY;
	wire		wr	= acc && PWRITE;
	wire	[7:0]	idx	= PADDR[9:2];
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RESETN);
	// ====
	// mode entry, wake and register effects
	AST_STOP_ON: assert property (
		wr && idx == 8'h87 && PWDATA[1] |=> !FAST_RC_OSC_EN && CPU_HALT)
		else $error("stop mode not entered");
	AST_IDLE_ON: assert property (
		wr && idx == 8'h87 && PWDATA[1:0] == 2'h1 |=> CPU_HALT && FAST_RC_OSC_EN)
		else $error("idle mode not entered");
	AST_STOP_QUIET: assert property (
		!FAST_RC_OSC_EN |-> !SYSCLK_TICK && !CONV_CLK_EN)
		else $error("clock enable active while stopped");
	AST_WDT_WAKE: assert property (
		!FAST_RC_OSC_EN && WDT_EVENT |-> ##[1:2] FAST_RC_OSC_EN)
		else $error("watchdog event did not wake");
	AST_EXT_WAKE: assert property (
		!FAST_RC_OSC_EN && EXT_IRQ_INPUTS != 3'h0 |-> ##[1:5] FAST_RC_OSC_EN)
		else $error("external interrupt did not wake");
	AST_IDLE_WAKE: assert property (
		CPU_HALT && FAST_RC_OSC_EN && IRQ_PENDING |-> ##[1:2] !CPU_HALT)
		else $error("pending interrupt did not leave idle");
	AST_ACK_CLR: assert property (
		WTIMER_IRQ_ACK && WAKEUP_TIMER_FLAG && !wr |=> !WAKEUP_TIMER_FLAG)
		else $error("timer flag not cleared on accept");
	AST_TRIM_WR: assert property (
		wr && idx == 8'h83 |=> FAST_OSC_TRIM == $past(PWDATA[7:0]))
		else $error("trim output differs from write");
	AST_XTAL_WR: assert property (
		wr && idx == 8'hC1 |=> CRYSTAL_SELECT == $past(PWDATA[6]))
		else $error("crystal select differs from write");
	AST_POWER_MODE_CONTROL_RD: assert property (
		acc && !PWRITE && idx == 8'h87 |-> PRDATA == 32'h0)
		else $error("power register read not zero");
endmodule // cplft_chk
bind cplft_top cplft_chk chk_u (.*);
`default_nettype wire

// ==== testbench/cplft_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====
// bench driving the block ports directly
module cplft_top_bench;
	// block ports
	logic		MCLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic	[11:0]	PADDR;
	logic	[31:0]	PWDATA, PRDATA, rd;
	logic	[7:0]	FACTORY_TRIM, FACTORY_OPTION, FAST_OSC_TRIM;
	logic	[2:0]	EXT_IRQ_INPUTS;
	logic		SLOW_RC_OSC, XTAL_CLK, WDT_EVENT, IRQ_PENDING, WTIMER_IRQ_ACK;
	logic		SYSCLK_TICK, CONV_CLK_EN, FAST_RC_OSC_EN, CPU_HALT, IRQ;
	logic		CRYSTAL_SELECT, BAUD_DOUBLE, WAKEUP_TIMER_FLAG;
	// bookkeeping
	int		n_mismatch, checked, n, s;
	cplft_top dut_u (.*);
	// 40 MHz system clock
	initial begin
		MCLK = 1'h0;
		forever #12.5 MCLK = ~MCLK;
	end
	// crystal runs free at eight system clocks a period
	initial begin
		XTAL_CLK = 1'h0;
		forever #100 XTAL_CLK = ~XTAL_CLK;
	end
	// ====
	// verdict and compare
	task give_verdict;
		if (n_mismatch == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// ====
	// one apb transfer, read data left in rd
	task apb(input logic w, input logic [7:0] i, input logic [31:0] d);
		int k;
		@(posedge MCLK);
		PSEL <= 1'h1;
		PWRITE <= w;
		PADDR <= {2'h0, i, 2'h0};
		PWDATA <= d;
		@(posedge MCLK);
		PENABLE <= 1'h1;
		k = 0;
		do begin
			@(posedge MCLK);
			k++;
		end while (PREADY !== 1'h1 && k < 20);
		if (PREADY !== 1'h1) begin
			n_mismatch++;
			give_verdict;
		end
		rd = PRDATA;
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
	endtask
	// sample just after an edge
	task settle;
		@(posedge MCLK);
		#1;
	endtask
	// bounded wait: 0 timer flag, 1 oscillator on, 2 cpu running
	task wait_hi(input int which, input int lim, output int cnt);
		cnt = 0;
		do begin
			settle;
			cnt++;
		end while (cnt < lim && !(which == 0 ? WAKEUP_TIMER_FLAG === 1'h1 :
			which == 1 ? FAST_RC_OSC_EN === 1'h1 : CPU_HALT === 1'h0));
	endtask
	// one-cycle pulse: 0 accept, 1 watchdog, 2 pending
	task pulse(input int w);
		@(posedge MCLK);
		case (w)
			0: WTIMER_IRQ_ACK <= 1'h1;
			1: WDT_EVENT <= 1'h1;
			default: IRQ_PENDING <= 1'h1;
		endcase
		@(posedge MCLK);
		{WTIMER_IRQ_ACK, WDT_EVENT, IRQ_PENDING} <= 3'h0;
	endtask
	// ====
	// main sequence
	initial begin
		{PSEL, PENABLE, PWRITE, SLOW_RC_OSC} = 4'h0;
		{WDT_EVENT, IRQ_PENDING, WTIMER_IRQ_ACK} = 3'h0;
		PADDR = 12'h0;
		PWDATA = 32'h0;
		EXT_IRQ_INPUTS = 3'h0;
		FACTORY_TRIM = 8'h5A;
		FACTORY_OPTION = 8'h30;
		RESETN = 1'h0;
		n_mismatch = 0;
		checked = 0;
		repeat (6) @(posedge MCLK);
		RESETN <= 1'h1;
		settle;
		settle;
		// power-on load, trim, write-only power register
		chk("trim out", 32'h5A, FAST_OSC_TRIM);
		apb(1'h0, 8'h83, 32'h0);
		chk("trim read", 32'h5A, rd);
		apb(1'h1, 8'h83, 32'h5B);
		settle;
		chk("trim write", 32'h5B, FAST_OSC_TRIM);
		apb(1'h1, 8'h87, 32'h80);
		apb(1'h0, 8'h87, 32'h0);
		chk("power read", 32'h0, rd);
		chk("baud", 32'h1, BAUD_DOUBLE);
		apb(1'h0, 8'h10, 32'h0);
		chk("unmapped error", 32'h1, PSLVERR);
		// divider codes over 24 cycles
		for (s = 0; s < 4; s++) begin
			apb(1'h1, 8'hC1, s << 4);
			settle;
			n = 0;
			repeat (24) begin
				settle;
				n += SYSCLK_TICK;
			end
			chk("ticks", 24 / (s == 3 ? 12 : 1 << s), n);
			chk("converter clock", 32'h1, CONV_CLK_EN);
		end
		// wake-up timer on crystal, periods 0 and 1
		apb(1'h1, 8'hC1, 32'h40);
		settle;
		chk("crystal", 32'h1, CRYSTAL_SELECT);
		for (s = 0; s < 2; s++) begin
			apb(1'h1, 8'hCE, 32'h0);
			apb(1'h1, 8'hCE, 32'h80 | s);
			wait_hi(0, 20000, n);
			chk("period seen", 32'h1, n < 20000);
			chk("masked irq", 32'h0, IRQ);
			pulse(0);
			wait_hi(0, 20000, n);
			chk("period", 4096 << s, n + 2);
		end
		// interrupt mask, hold, clear
		apb(1'h1, 8'hE1, 32'h1);
		settle;
		chk("irq", 32'h1, IRQ);
		apb(1'h1, 8'hCE, 32'h0);
		wait_hi(0, 5000, n);
		chk("held", 32'd5000, n);
		apb(1'h1, 8'hE0, 32'h7);
		settle;
		chk("irq clear", 32'h0, IRQ);
		// stop, woken by watchdog, external line, timer
		for (s = 0; s < 3; s++) begin
			if (s == 2)
				apb(1'h1, 8'hCE, 32'h80);
			apb(1'h1, 8'h87, 32'h2);
			settle;
			chk("stop osc", 32'h0, FAST_RC_OSC_EN);
			chk("stop conv", 32'h0, CONV_CLK_EN);
			chk("stop tick", 32'h0, SYSCLK_TICK);
			chk("stop halt", 32'h1, CPU_HALT);
			if (s == 0)
				pulse(1);
			if (s == 1) begin
				@(posedge MCLK);
				EXT_IRQ_INPUTS <= 3'h4;
			end
			wait_hi(1, 6000, n);
			chk("stop wake", 32'h1, n < 6000);
			@(posedge MCLK);
			EXT_IRQ_INPUTS <= 3'h0;
			apb(1'h0, 8'hE2, 32'h0);
			chk("mode run", 32'h0, rd);
			apb(1'h0, 8'hE0, 32'h0);
			chk("stop wake status", 32'h2, rd & 32'h2);
			apb(1'h1, 8'hCE, 32'h0);
			apb(1'h1, 8'hE0, 32'h7);
		end
		// idle and its wake
		apb(1'h1, 8'h87, 32'h1);
		settle;
		chk("idle halt", 32'h1, CPU_HALT);
		chk("idle osc", 32'h1, FAST_RC_OSC_EN);
		apb(1'h0, 8'hE2, 32'h0);
		chk("mode idle", 32'h1, rd);
		pulse(2);
		wait_hi(2, 20, n);
		chk("idle wake", 32'h1, n < 20);
		apb(1'h0, 8'hE0, 32'h0);
		chk("idle wake status", 32'h4, rd & 32'h4);
		give_verdict;
	end
endmodule // cplft_top_bench
`default_nettype wire
